/* File: rtl/gpio_port_pkg.sv */
// Constants, register map and carrier types of the port block.
// Assumes a classic Wishbone master with 32-bit data on one 10 MHz clock.
`default_nettype none

package gpio_port_pkg;

  // ----------------------------------------------------------------
  // Bus and clock
  // ----------------------------------------------------------------
  localparam int          ADR_W        = 8;
  localparam int          DAT_W        = 32;
  localparam int          CLK_HZ       = 10_000_000;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_PULLUP0  = 8'h00;
  localparam logic [7:0]  OFS_DATA0    = 8'h04;
  localparam logic [7:0]  OFS_DIR0     = 8'h08;
  localparam logic [7:0]  OFS_CTRL1H   = 8'h0C;
  localparam logic [7:0]  OFS_DATA1H   = 8'h10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_PULLUP0  = 8'h00;
  localparam logic [7:0]  RST_DATA0    = 8'h00;
  localparam logic [7:0]  RST_DIR0     = 8'h00;
  localparam logic [7:0]  RST_CTRL1H   = 8'h55;
  localparam logic [3:0]  RST_DATA1H   = 4'hF;

  // ----------------------------------------------------------------
  // Pin mode field codes and field layout
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_INPUT   = 2'h0;
  localparam logic [1:0]  MODE_OPEN    = 2'h1;
  localparam logic [1:0]  MODE_ALT     = 2'h2;
  localparam logic [1:0]  MODE_PUSH    = 2'h3;
  localparam int          FIELD_W      = 2;
  localparam int          HI_PINS      = 4;

  // Alternative routing: index into the upper nibble (pin 4 = 0)
  localparam int          ALT_RXD      = 0;
  localparam int          ALT_TXD      = 1;
  localparam int          ALT_SDA      = 2;
  localparam int          ALT_SCL      = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [HI_PINS-1:0] out;
    logic [HI_PINS-1:0] oe;
  } alt_drive_t;

  typedef struct packed {
    logic [7:0]       pullup0;
    logic [7:0]       data0;
    logic [7:0]       dir0;
    logic [7:0]       ctrl1h;
    logic [3:0]       data1h;
    logic             ack;
    logic [DAT_W-1:0] rdat;
  } port_state_t;

endpackage

`default_nettype wire

/* File: rtl/pin_mode_cell.sv */
// One second-port pin: turns a two-bit mode field into pin drive.
// Assumes the mode code, latch bit and peripheral drive are stable per cycle.
`default_nettype none

module pin_mode_cell (
  input  wire logic [1:0] mode_i,    // Two-bit pin mode field
  input  wire logic       data_i,    // Port data latch bit
  input  wire logic       alt_out_i, // Peripheral output level
  input  wire logic       alt_oe_i,  // Peripheral output enable
  output logic            pin_o,     // Pin output level
  output logic            pin_oe_o,  // Pin output enable
  output logic            is_out_o   // Pin is a plain output
);
  import gpio_port_pkg::*;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // field selects mode
  always_comb begin
    pin_o    = 1'b0;
    pin_oe_o = 1'b0;
    is_out_o = 1'b0;
    case (mode_i)
      MODE_OPEN: begin
        // Pull low on 0, release on 1
        pin_oe_o = ~data_i;
        is_out_o = 1'b1;
      end
      MODE_ALT: begin
        pin_o    = alt_out_i;
        pin_oe_o = alt_oe_i;
      end
      MODE_PUSH: begin
        pin_o    = data_i;
        pin_oe_o = 1'b1;
        is_out_o = 1'b1;
      end
      default: begin
        pin_oe_o = 1'b0;   // Schmitt input
      end
    endcase
  end

endmodule

`default_nettype wire

/* File: rtl/port_pullup_data_pinmode.sv */
// Port registers: first-port pull-ups and data, second-port upper modes.
// Assumes a classic Wishbone master on clk_i and a synchronous reset.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`default_nettype none

module port_pullup_data_pinmode (
  input  wire logic                         clk_i,      // 10 MHz clock
  input  wire logic                         rst_i,      // Sync reset, high
  input  wire gpio_port_pkg::wb_req_t       wb_i,       // Bus request
  output logic [gpio_port_pkg::DAT_W-1:0]   wb_dat_o,   // Read data
  output logic                              wb_ack_o,   // Bus acknowledge
  input  wire logic [7:0]                   port0_i,    // First port levels
  output logic [7:0]                        port0_o,    // First port drive
  output logic [7:0]                        port0_oe_o, // First port enable
  output logic [7:0]                        pullup0_o,  // Pull-up connect
  input  wire logic [3:0]                   port1h_i,   // Pins 7..4 levels
  output logic [3:0]                        port1h_o,   // Pins 7..4 drive
  output logic [3:0]                        port1h_oe_o,// Pins 7..4 enable
  input  wire gpio_port_pkg::alt_drive_t    alt_i,      // Peripheral drive
  output logic [3:0]                        alt_in_o,   // Pin levels to periph
  output logic [3:0]                        alt_sel_o   // Alt mode selected
);
  import gpio_port_pkg::*;

  port_state_t    st_reg;
  port_state_t    st_next;
  logic           req;
  logic           wr;
  logic [7:0]     rd_byte;
  logic [7:0]     port0_view;
  logic [3:0]     port1_view;
  logic [3:0]     is_out1;

  // ----------------------------------------------------------------
  // Bus qualification
  // ----------------------------------------------------------------
  // One access per request; ack drops the cycle after it was given
  assign req = wb_i.cyc & wb_i.stb & ~st_reg.ack;
  assign wr  = req & wb_i.we & wb_i.sel[0];

  // ----------------------------------------------------------------
  // Pin state as seen by software
  // ----------------------------------------------------------------
  // Output pins read back the latch, input pins read the pad
  assign port0_view = (st_reg.dir0 & st_reg.data0) | (~st_reg.dir0 & port0_i);
  assign port1_view = (is_out1 & st_reg.data1h) | (~is_out1 & port1h_i);

  // Read multiplexer
  always_comb begin
    rd_byte = 8'h00;
    if (wb_i.adr == OFS_PULLUP0) begin
      rd_byte = st_reg.pullup0;
    end else if (wb_i.adr == OFS_DATA0) begin
      rd_byte = port0_view;
    end else if (wb_i.adr == OFS_DIR0) begin
      rd_byte = st_reg.dir0;
    end else if (wb_i.adr == OFS_CTRL1H) begin
      rd_byte = st_reg.ctrl1h;
    end else if (wb_i.adr == OFS_DATA1H) begin
      rd_byte = {4'h0, port1_view};
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.ack  = req;
    if (req) begin
      st_next.rdat = {24'h000000, rd_byte};
    end
    if (wr) begin
      if (wb_i.adr == OFS_PULLUP0) begin
        st_next.pullup0 = wb_i.dat[7:0];
      end else if (wb_i.adr == OFS_DATA0) begin
        st_next.data0 = wb_i.dat[7:0];
      end else if (wb_i.adr == OFS_DIR0) begin
        st_next.dir0 = wb_i.dat[7:0];
      end else if (wb_i.adr == OFS_CTRL1H) begin
        st_next.ctrl1h = wb_i.dat[7:0];
      end else if (wb_i.adr == OFS_DATA1H) begin
        st_next.data1h = wb_i.dat[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.pullup0 <= RST_PULLUP0;
      st_reg.data0   <= RST_DATA0;
      st_reg.dir0    <= RST_DIR0;
      st_reg.ctrl1h  <= RST_CTRL1H;
      st_reg.data1h  <= RST_DATA1H;
      st_reg.ack     <= 1'b0;
      st_reg.rdat    <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdat;

  // ----------------------------------------------------------------
  // First port pins
  // ----------------------------------------------------------------
  // pull-up connect
  assign pullup0_o  = st_reg.pullup0;
  assign port0_o    = st_reg.data0;
  assign port0_oe_o = st_reg.dir0;

  // ----------------------------------------------------------------
  // Second port upper pins
  // ----------------------------------------------------------------
  // alt routing per pin
  genvar g;
  generate
    for (g = 0; g < HI_PINS; g++) begin : g_pin
      pin_mode_cell u_cell (
        .mode_i    (st_reg.ctrl1h[g*FIELD_W +: FIELD_W]),
        .data_i    (st_reg.data1h[g]),
        .alt_out_i (alt_i.out[g]),
        .alt_oe_i  (alt_i.oe[g]),
        .pin_o     (port1h_o[g]),
        .pin_oe_o  (port1h_oe_o[g]),
        .is_out_o  (is_out1[g])
      );
      assign alt_sel_o[g] =
        (st_reg.ctrl1h[g*FIELD_W +: FIELD_W] == MODE_ALT);
    end
  endgenerate

  assign alt_in_o = port1h_i;

endmodule

`default_nettype wire

/* File: test/port_pads_model.sv */
// Board side of the port pins: resolves each pad from the block's drive.
// Assumes one clock; undriven pads without a pull-up wander every cycle.
`default_nettype none

module port_pads_model (
  input  wire logic       clk_i,  // Bench clock
  input  wire logic [7:0] drv0_i, // First port drive
  input  wire logic [7:0] oe0_i,  // First port enable
  input  wire logic [7:0] pu0_i,  // Pull-up connect
  input  wire logic [3:0] drv1_i, // Upper pins drive
  input  wire logic [3:0] oe1_i,  // Upper pins enable
  output logic      [7:0] pad0_o, // First port levels
  output logic      [3:0] pad1_o  // Upper pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last0 = 8'h00;
  logic [3:0] last1 = 4'h0;

  // Floating pads flip each cycle, pulled-up pads read high
  always_ff @(posedge clk_i) begin
    last0 <= pad0_o;
    last1 <= pad1_o;
  end
  assign pad0_o = (oe0_i & drv0_i) | (~oe0_i & (pu0_i | ~last0));
  assign pad1_o = (oe1_i & drv1_i) | (~oe1_i & ~last1);
endmodule

`default_nettype wire

/* File: test/port_pullup_data_pinmode_sva.sv */
// Checker on the port block's bus, pull-up and pin-mode outputs.
// Assumes the bind below and a bus master that releases after ack.
`default_nettype none

module port_checker
  import gpio_port_pkg::*;
(
  input  wire logic             clk_i,       // Clock
  input  wire logic             rst_i,       // Reset
  input  wire wb_req_t          wb_i,        // Bus request
  input  wire logic [DAT_W-1:0] wb_dat_o,    // Read data
  input  wire logic             wb_ack_o,    // Acknowledge
  input  wire logic [7:0]       port0_o,     // First port drive
  input  wire logic [7:0]       pullup0_o,   // Pull-ups
  input  wire logic [3:0]       port1h_i,    // Upper levels
  input  wire logic [3:0]       port1h_o,    // Upper drive
  input  wire logic [3:0]       port1h_oe_o, // Upper enable
  input  wire alt_drive_t       alt_i,       // Peripheral drive
  input  wire logic [3:0]       alt_in_o,    // Levels to periph
  input  wire logic [3:0]       alt_sel_o    // Alt selected
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  assign take = wb_i.cyc && wb_i.stb && !wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr(logic [7:0] a);
    take && wb_i.we && wb_i.sel[0] && wb_i.adr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    take && !wb_i.we && wb_i.adr == a;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_ack_one: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_high: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_unmapped_rd: assert property (s_rd(8'h20) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_rst_modes: assert property ($fell(rst_i) |->
    port1h_oe_o == 4'h0 && port1h_o == 4'h0 && alt_sel_o == 4'h0)
    else $error("upper pins not open-drain high after reset");
  chk_pullup_wr: assert property (s_wr(OFS_PULLUP0) |=>
    pullup0_o == $past(wb_i.dat[7:0])) else $error("pull-up write lost");
  chk_data_wr: assert property (s_wr(OFS_DATA0) |=>
    port0_o == $past(wb_i.dat[7:0])) else $error("data write lost");
  chk_data_hold: assert property (!(take && wb_i.we) |=>
    $stable(port0_o)) else $error("port data changed without write");
  chk_alt_route: assert property ((((alt_i.out ^ port1h_o) |
    (alt_i.oe ^ port1h_oe_o)) & alt_sel_o) == 4'h0)
    else $error("alt pin not driven by peripheral");
  chk_alt_in: assert property (alt_in_o == port1h_i)
    else $error("pin level not passed to peripheral");
endmodule

bind port_pullup_data_pinmode port_checker port_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .port0_o(port0_o), .pullup0_o(pullup0_o),
  .port1h_i(port1h_i), .port1h_o(port1h_o), .port1h_oe_o(port1h_oe_o),
  .alt_i(alt_i), .alt_in_o(alt_in_o), .alt_sel_o(alt_sel_o));

`default_nettype wire

/* File: test/tb_port_pullup_data_pinmode.sv */
// Self-checking bench for the port block over classic Wishbone.
// Assumes the pad model on the pins and a 10 MHz clock.
`default_nettype none

module tb_port_pullup_data_pinmode;
  import gpio_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wb_req_t     wb    = '0;
  alt_drive_t  alt   = '0;
  logic [31:0] wb_dat;
  logic        wb_ack;
  logic [7:0]  p0_in, p0_out, p0_oe, pu;
  logic [3:0]  p1_in, p1_out, p1_oe, a_in, a_sel;
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #50 clk_i = ~clk_i;

  port_pullup_data_pinmode port_pullup_data_pinmode_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .port0_i(p0_in), .port0_o(p0_out), .port0_oe_o(p0_oe), .pullup0_o(pu),
    .port1h_i(p1_in), .port1h_o(p1_out), .port1h_oe_o(p1_oe), .alt_i(alt),
    .alt_in_o(a_in), .alt_sel_o(a_sel));
  port_pads_model port_pads_model_i (.clk_i(clk_i), .drv0_i(p0_out),
    .oe0_i(p0_oe), .pu0_i(pu), .drv1_i(p1_out), .oe1_i(p1_oe),
    .pad0_o(p0_in), .pad1_o(p1_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task summarize();
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // One classic cycle: hold until ack is sampled, then release
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{cyc:1'b1, stb:1'b1, we:w, adr:a, sel:4'hF, dat:{24'h0, d}};
    // Look at ack mid-cycle, where it has settled
    do begin
      @(negedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    q = wb_dat;
    // Ack still stands at this edge; release right after it
    @(posedge clk_i);
    wb <= '0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(e, q);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    rd(OFS_CTRL1H, 32'h55);
    rd(OFS_PULLUP0, 32'h00);
    rd(8'h20, 32'h00);
    $display("test reset done");
  endtask
  task t_pullup();
    wr(OFS_PULLUP0, 8'hA5);
    chk(32'hA5, {24'h0, pu});
    rd(OFS_PULLUP0, 32'hA5);
    $display("test pullup done");
  endtask
  task t_data();
    wr(OFS_DATA0, 8'h3C);
    wr(OFS_DIR0, 8'h0F);
    wr(OFS_PULLUP0, 8'hF0);
    chk(32'h3C, {24'h0, p0_out});
    chk(32'h0F, {24'h0, p0_oe});
    rd(OFS_DATA0, 32'hFC);
    $display("test data done");
  endtask
  task t_modes();
    // Peripheral side enabled along with the pin selection
    alt <= '{out:4'hF, oe:4'hF};
    wr(OFS_CTRL1H, 8'hE4);
    wr(OFS_DATA1H, 8'h05);
    chk(32'hE, {28'h0, p1_oe});
    chk(32'h4, {28'h0, p1_out & 4'hE});
    chk(32'h4, {28'h0, a_sel});
    alt <= '{out:4'h9, oe:4'h3};
    wr(OFS_CTRL1H, 8'hAA);
    chk(32'h9, {28'h0, p1_out});
    chk(32'h3, {28'h0, p1_oe});
    chk(32'hF, {28'h0, a_sel});
    rd(OFS_CTRL1H, 32'hAA);
    $display("test modes done");
  endtask
  task t_rerun();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CTRL1H, 32'h55);
    chk(32'h0, {24'h0, pu});
    $display("test rerun done");
  endtask

  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pullup();
    t_data();
    t_modes();
    t_rerun();
    summarize();
  end
  initial begin
    #200us;
    error_cnt++;
    summarize();
  end
endmodule

`default_nettype wire
